// [status_event_reporting.sv]
`timescale 1ns/1ps
`include "status_event_consts.svh"
// Function
// - Timebase state reads 0 internal-no-ref, 1 external, 2 internal-forced.
// - Auto setting 0 forces internal; 1 takes external whenever present.
// - Standard latch read returns whole or one bit, clearing exactly that.
// - Standard bits hold until read, clear-status, or any power-up; poweron_status_clear_i is ignored.
// - Bit0 operation complete, bit6 front-panel activity, bit7 power-on; bit1 unused.
// - Bits 2..5: query lost, device error, execution error, command error.
// - Standard mask takes whole-value write or single-bit write.
// - Standard mask query returns whole mask or one bit, unchanged.
// - Status byte bit 5 set when any enabled standard bit latched.
// - Instrument latch read returns whole or one bit, clearing accordingly.
// - Instrument bits 0..4 latch selftest, key, knob, remote set, range change.
// - Instrument bit 12 latches lock acquired, bit 13 lock lost.
// - Instrument bit 14 error posted, bit 15 query refused.
// - Instrument mask takes whole or single-bit writes; queries return mask or bit.
// - Instrument summary bit set when any enabled instrument bit latched.
// - Measurement latch read returns whole or one bit, clearing accordingly.
// - Measurement bits 0..2: voltage limit, potential overload, current overload.
// - Measurement bits 3..5 aux overloads, 6 no amplifier, 7 current limit.
// - Status byte bit 1 set when any enabled measurement bit latched.
// - Status byte bit 4 shows reply waiting; status byte reads never clear.
// - Service-request bit 6 set when any enabled status byte bit set.
// - Clear-status clears all three latches and aborts any scan.

module status_event_reporting (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input status_event_pkg::cmd_s cmd_i,
	output status_event_pkg::reply_s reply_o,
	input status_event_pkg::events_s events_i,
	input wire logic clear_status_i,
	input wire logic poweron_status_clear_i,
	input wire logic ext_ref_present_i,
	input wire logic msg_avail_i,
	input wire logic rx_full_i,
	output logic use_external_o,
	output logic [1:0] timebase_state_o,
	output logic [7:0] status_byte_o,
	output logic service_request_o,
	output logic abort_scan_o
);
	import status_event_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************

	// Reply value: whole register or the selected bit as 0/1
	function automatic logic [15:0] pick(input logic [15:0] value, input logic bit_mode, input logic [3:0] idx);
		logic [15:0] res;
		res = value;
		if (bit_mode) begin
			res = {15'h0000, value[idx]};
		end
		return res;
	endfunction

	// Bits a clearing read removes: all, or the returned one
	function automatic logic [15:0] clr_mask(input logic hit, input logic bit_mode, input logic [3:0] idx);
		logic [15:0] res;
		res = 16'h0000;
		if (hit) begin
			res = bit_mode ? (16'h0001 << idx) : 16'hffff;
		end
		return res;
	endfunction

	// Mask write: whole value or one bit forced to wdata[0]
	function automatic logic [15:0] mask_write(input logic [15:0] old, input cmd_s c);
		logic [15:0] res;
		res = c.wdata;
		if (c.bit_mode) begin
			res = old;
			res[c.idx] = c.wdata[0];
		end
		return res;
	endfunction

	state_s st;
	state_s next_st;
	logic q_hit;
	logic s_hit;
	logic [15:0] std_clr;
	logic [15:0] ins_clr;
	logic [15:0] mes_clr;
	logic [7:0] std_set;
	logic [7:0] stb_raw;
	logic [7:0] stb;
	logic [15:0] mask_new;

	// ****************************************
	// Timebase selection
	// ****************************************

	// Automatic mode follows the reference presence directly
	always_comb begin
		use_external_o = st.auto_tb & ext_ref_present_i;
		if (!ext_ref_present_i) begin
			timebase_state_o = `TB_INTERNAL_ONLY;
		end else if (st.auto_tb) begin
			timebase_state_o = `TB_EXTERNAL;
		end else begin
			timebase_state_o = `TB_INTERNAL_FORCED;
		end
	end

	// ****************************************
	// Status byte promotion
	// ****************************************

	// Summary bits are pure logic so they drop as soon as the source clears
	always_comb begin
		stb_raw = 8'h00;
		stb_raw[`SB_INS_SUM_BIT] = |(st.ins_latch & st.ins_mask);
		stb_raw[`SB_MES_SUM_BIT] = |(st.mes_latch & st.mes_mask);
		stb_raw[`SB_MSG_AVAIL_BIT] = msg_avail_i;
		stb_raw[`SB_STD_SUM_BIT] = |(st.std_latch & st.std_mask);
		stb_raw[`SB_RX_FULL_BIT] = rx_full_i;
		stb = stb_raw;
		stb[`SB_SRQ_BIT] = |(stb_raw & st.srq_mask);
	end

	assign status_byte_o = stb;
	assign service_request_o = stb[`SB_SRQ_BIT];
	assign abort_scan_o = st.abort_scan;
	assign reply_o = st.reply;

	// ****************************************
	// Next-state logic
	// ****************************************

	// Event sources, clears, mask writes and query replies
	always_comb begin
		next_st = st;
		q_hit = cmd_i.valid && (cmd_i.op == OP_QUERY);
		s_hit = cmd_i.valid && (cmd_i.op == OP_SET);
		std_clr = clr_mask(q_hit && cmd_i.target == T_STD_LATCH, cmd_i.bit_mode, cmd_i.idx);
		ins_clr = clr_mask(q_hit && cmd_i.target == T_INS_LATCH, cmd_i.bit_mode, cmd_i.idx);
		mes_clr = clr_mask(q_hit && cmd_i.target == T_MES_LATCH, cmd_i.bit_mode, cmd_i.idx);
		if (clear_status_i) begin
			std_clr = 16'hffff;
			ins_clr = 16'hffff;
			mes_clr = 16'hffff;
		end
		// Bit 1 has no source; power-on raised once after reset release
		std_set = events_i.std_ev;
		std_set[`SE_UNUSED_BIT] = 1'b0;
		std_set[`SE_POWER_ON_BIT] = events_i.std_ev[`SE_POWER_ON_BIT] | st.pon_pending;
		next_st.pon_pending = 1'b0;
		// Set wins over any clear in the same cycle
		next_st.std_latch = (st.std_latch & ~std_clr[7:0]) | std_set;
		next_st.ins_latch = (st.ins_latch & ~ins_clr) | events_i.ins_ev;
		next_st.mes_latch = (st.mes_latch & ~mes_clr[7:0]) | events_i.mes_ev;
		next_st.abort_scan = clear_status_i;
		next_st.reply.valid = q_hit;
		next_st.reply.data = 16'h0000;
		mask_new = 16'h0000;
		if (q_hit) begin
			case (cmd_i.target)
				T_STD_LATCH: next_st.reply.data = pick({8'h00, st.std_latch}, cmd_i.bit_mode, cmd_i.idx);
				T_STD_MASK: next_st.reply.data = pick({8'h00, st.std_mask}, cmd_i.bit_mode, cmd_i.idx);
				T_INS_LATCH: next_st.reply.data = pick(st.ins_latch, cmd_i.bit_mode, cmd_i.idx);
				T_INS_MASK: next_st.reply.data = pick(st.ins_mask, cmd_i.bit_mode, cmd_i.idx);
				T_MES_LATCH: next_st.reply.data = pick({8'h00, st.mes_latch}, cmd_i.bit_mode, cmd_i.idx);
				T_MES_MASK: next_st.reply.data = pick({8'h00, st.mes_mask}, cmd_i.bit_mode, cmd_i.idx);
				T_SRQ_MASK: next_st.reply.data = pick({8'h00, st.srq_mask}, cmd_i.bit_mode, cmd_i.idx);
				T_STATUS_BYTE: next_st.reply.data = pick({8'h00, stb}, cmd_i.bit_mode, cmd_i.idx);
				T_TIMEBASE: next_st.reply.data = {14'h0000, timebase_state_o};
				T_AUTO_TB: next_st.reply.data = {15'h0000, st.auto_tb};
				default: next_st.reply.data = 16'h0000;
			endcase
		end
		// 8-bit registers ignore bit indices above 7
		if (s_hit) begin
			case (cmd_i.target)
				T_STD_MASK: begin
					mask_new = mask_write({8'h00, st.std_mask}, cmd_i);
					if (!(cmd_i.bit_mode && cmd_i.idx[3])) begin
						next_st.std_mask = mask_new[7:0];
					end
				end
				T_INS_MASK: next_st.ins_mask = mask_write(st.ins_mask, cmd_i);
				T_MES_MASK: begin
					mask_new = mask_write({8'h00, st.mes_mask}, cmd_i);
					if (!(cmd_i.bit_mode && cmd_i.idx[3])) begin
						next_st.mes_mask = mask_new[7:0];
					end
				end
				T_SRQ_MASK: begin
					mask_new = mask_write({8'h00, st.srq_mask}, cmd_i);
					if (!(cmd_i.bit_mode && cmd_i.idx[3])) begin
						next_st.srq_mask = mask_new[7:0];
					end
				end
				T_AUTO_TB: next_st.auto_tb = cmd_i.wdata[0];
				default: next_st.auto_tb = st.auto_tb;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************

	// Reset is power-up: latches start clear, power-on event pending
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st.std_latch <= `LATCH8_RST;
			st.std_mask <= `MASK8_RST;
			st.ins_latch <= `LATCH16_RST;
			st.ins_mask <= `MASK16_RST;
			st.mes_latch <= `LATCH8_RST;
			st.mes_mask <= `MASK8_RST;
			st.srq_mask <= `MASK8_RST;
			st.auto_tb <= `AUTO_TB_RST;
			st.pon_pending <= `PON_PENDING_RST;
			st.abort_scan <= `ABORT_RST;
			st.reply <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Checks
	// ****************************************

	tb_state_code_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		timebase_state_o == (!ext_ref_present_i ? 2'h0 : (st.auto_tb ? 2'h1 : 2'h2)))
		else $error("timebase state code wrong");

	manual_internal_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!st.auto_tb |-> !use_external_o)
		else $error("manual mode uses external reference");

	std_read_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(q_hit && cmd_i.target == T_STD_LATCH && !cmd_i.bit_mode && events_i.std_ev == 8'h00
		&& !st.pon_pending) |=> (st.std_latch == 8'h00 && reply_o.data[7:0] == $past(st.std_latch)))
		else $error("standard read did not return and clear");

	std_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(!clear_status_i && !(q_hit && cmd_i.target == T_STD_LATCH)) |=> ((st.std_latch & $past(st.std_latch))
		== $past(st.std_latch)))
		else $error("standard bit lost without clear");

	unused_bit_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!st.std_latch[`SE_UNUSED_BIT])
		else $error("unused standard bit set");

	mask_query_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(q_hit && cmd_i.target == T_STD_MASK && cmd_i.bit_mode) |=> (reply_o.valid && $stable(st.std_mask)
		&& reply_o.data == {15'h0000, !$past(cmd_i.idx[3]) && $past(st.std_mask[cmd_i.idx[2:0]])}))
		else $error("mask bit query wrong or mask altered");

	std_summary_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		status_byte_o[`SB_STD_SUM_BIT] == |(st.std_latch & st.std_mask))
		else $error("standard summary bit wrong");

	ins_bit_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(q_hit && cmd_i.target == T_INS_LATCH && cmd_i.bit_mode && !clear_status_i) |=>
		((st.ins_latch | (16'h0001 << $past(cmd_i.idx))) == ($past(st.ins_latch) | $past(events_i.ins_ev)
		| (16'h0001 << $past(cmd_i.idx)))))
		else $error("instrument bit read cleared other bits");

	srq_promote_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		service_request_o == |({status_byte_o[7], 1'b0, status_byte_o[5:0]} & st.srq_mask))
		else $error("service request wrong");

	clear_all_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(clear_status_i && events_i == '0 && !st.pon_pending) |=> (st.ins_latch == 16'h0000
		&& st.mes_latch == 8'h00 && st.std_latch == 8'h00 && abort_scan_o))
		else $error("clear status incomplete");

	set_wins_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(q_hit && cmd_i.target == T_MES_LATCH && events_i.mes_ev != 8'h00) |=>
		((st.mes_latch & $past(events_i.mes_ev)) == $past(events_i.mes_ev)))
		else $error("event lost to clearing read");

	mask_whole_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(s_hit && cmd_i.target == T_STD_MASK && !cmd_i.bit_mode) |=> (st.std_mask == $past(cmd_i.wdata[7:0])))
		else $error("standard mask whole write lost");

	ins_mask_bit_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(s_hit && cmd_i.target == T_INS_MASK && cmd_i.bit_mode) |=>
		(st.ins_mask[$past(cmd_i.idx)] == $past(cmd_i.wdata[0])))
		else $error("instrument mask bit write lost");

	ins_summary_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		((events_i.ins_ev & st.ins_mask) != 16'h0000 && !s_hit) |=> status_byte_o[`SB_INS_SUM_BIT])
		else $error("instrument summary bit missing");

	mes_summary_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		((events_i.mes_ev & st.mes_mask) != 8'h00 && !s_hit) |=> status_byte_o[`SB_MES_SUM_BIT])
		else $error("measurement summary bit missing");

	status_reply_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(q_hit && cmd_i.target == T_STATUS_BYTE && !cmd_i.bit_mode) |=>
		(reply_o.data == {8'h00, $past(status_byte_o)}))
		else $error("status byte reply wrong");

	abort_only_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		abort_scan_o |-> $past(clear_status_i))
		else $error("abort without clear status");

endmodule // status_event_reporting

// [status_event_consts.svh]
`ifndef STATUS_EVENT_CONSTS_SVH
`define STATUS_EVENT_CONSTS_SVH

// ****************************************
// Standard event bit positions
// ****************************************
`define SE_OPC_BIT 0
`define SE_UNUSED_BIT 1
`define SE_QUERY_LOST_BIT 2
`define SE_DEV_ERR_BIT 3
`define SE_EXEC_ERR_BIT 4
`define SE_CMD_ERR_BIT 5
`define SE_USER_REQ_BIT 6
`define SE_POWER_ON_BIT 7

// ****************************************
// Status byte bit positions
// ****************************************
`define SB_INS_SUM_BIT 0
`define SB_MES_SUM_BIT 1
`define SB_MSG_AVAIL_BIT 4
`define SB_STD_SUM_BIT 5
`define SB_SRQ_BIT 6
`define SB_RX_FULL_BIT 7

// ****************************************
// Timebase state codes and reset values
// ****************************************
`define TB_INTERNAL_ONLY 2'h0
`define TB_EXTERNAL 2'h1
`define TB_INTERNAL_FORCED 2'h2
`define AUTO_TB_RST 1'h1
`define MASK8_RST 8'h00
`define MASK16_RST 16'h0000
`define LATCH8_RST 8'h00
`define LATCH16_RST 16'h0000
`define PON_PENDING_RST 1'h1
`define ABORT_RST 1'h0

`endif

// [status_event_pkg.sv]
package status_event_pkg;

	// Remote operation: query or set
	typedef enum logic {
		OP_QUERY,
		OP_SET
	} op_e;

	// Addressed register
	typedef enum logic [3:0] {
		T_STD_LATCH,
		T_STD_MASK,
		T_INS_LATCH,
		T_INS_MASK,
		T_MES_LATCH,
		T_MES_MASK,
		T_SRQ_MASK,
		T_STATUS_BYTE,
		T_TIMEBASE,
		T_AUTO_TB
	} target_e;

	typedef struct packed {
		logic valid;
		op_e op;
		target_e target;
		logic bit_mode;
		logic [3:0] idx;
		logic [15:0] wdata;
	} cmd_s;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} reply_s;

	typedef struct packed {
		logic [7:0] std_ev;
		logic [15:0] ins_ev;
		logic [7:0] mes_ev;
	} events_s;

	typedef struct packed {
		logic [7:0] std_latch;
		logic [7:0] std_mask;
		logic [15:0] ins_latch;
		logic [15:0] ins_mask;
		logic [7:0] mes_latch;
		logic [7:0] mes_mask;
		logic [7:0] srq_mask;
		logic auto_tb;
		logic pon_pending;
		logic abort_scan;
		reply_s reply;
	} state_s;

endpackage

// [remote_host.sv]
`timescale 1ns/1ps
// ************************************
// Remote host issuing one command a time
// ************************************
module remote_host (
	input wire logic core_clk_i,
	output status_event_pkg::cmd_s cmd_o
);
	import status_event_pkg::*;

	// Idle bus carries no request
	initial cmd_o = '0;

	// Raised off the sampling edge, held one cycle, then payload scrambled
	task automatic send(input op_e op, input target_e tg, input logic bm, input logic [3:0] idx,
		input logic [15:0] wd);
		@(negedge core_clk_i);
		cmd_o <= '{valid: 1'b1, op: op, target: tg, bit_mode: bm, idx: idx, wdata: wd};
		@(negedge core_clk_i);
		cmd_o <= '{valid: 1'b0, op: op, target: tg, bit_mode: ~bm, idx: ~idx, wdata: ~wd};
	endtask
endmodule // remote_host

// [status_event_reporting_tb.sv]
`timescale 1ns/1ps
module status_event_reporting_tb;
	import status_event_pkg::*;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	cmd_s cmd_i;
	reply_s reply_o;
	events_s events_i = '0;
	logic clear_status_i = 1'b0;
	logic ext_ref_present_i = 1'b0;
	logic msg_avail_i = 1'b0;
	logic rx_full_i = 1'b0;
	logic use_external_o;
	logic [1:0] timebase_state_o;
	logic [7:0] status_byte_o;
	logic service_request_o;
	logic abort_scan_o;
	int failures = 0;
	int n_checks = 0;
	logic [15:0] exp_q[$];
	logic [15:0] lfsr = 16'he821;

	// 40 MHz clock
	always #12.5 core_clk_i = ~core_clk_i;

	remote_host u_host (.core_clk_i(core_clk_i), .cmd_o(cmd_i));
	status_event_reporting u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
		.reply_o(reply_o), .events_i(events_i), .clear_status_i(clear_status_i),
		.poweron_status_clear_i(1'b0), .ext_ref_present_i(ext_ref_present_i), .msg_avail_i(msg_avail_i),
		.rx_full_i(rx_full_i), .use_external_o(use_external_o), .timebase_state_o(timebase_state_o),
		.status_byte_o(status_byte_o), .service_request_o(service_request_o), .abort_scan_o(abort_scan_o));

	// ************************************
	// Helpers
	// ************************************
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic ask(input target_e tg, input logic bm, input logic [3:0] idx, input logic [15:0] exp);
		exp_q.push_back(exp);
		u_host.send(OP_QUERY, tg, bm, idx, 16'h0000);
	endtask

	task automatic put(input target_e tg, input logic bm, input logic [3:0] idx, input logic [15:0] wd);
		u_host.send(OP_SET, tg, bm, idx, wd);
	endtask

	task automatic pulse(input events_s e);
		@(negedge core_clk_i);
		events_i <= e;
		@(negedge core_clk_i);
		events_i <= '0;
	endtask

	// Status byte and its service request copy, sampled mid-cycle
	task automatic sb(input logic [7:0] exp);
		@(negedge core_clk_i);
		check({8'h00, status_byte_o}, {8'h00, exp}, "status byte");
		check({15'h0000, service_request_o}, {15'h0000, exp[6]}, "service request");
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Replies are one cycle wide, so look at every edge
	always @(posedge core_clk_i) begin
		#1;
		if (reply_o.valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(16'hffff, 16'h0000, "reply without query");
			else
				check(reply_o.data, exp_q.pop_front(), "reply");
		end
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk_i);
		failures++;
		$display("unexpected at %0t: run timed out", $time);
		finish_test();
	end

	// ************************************
	// Main sequence
	// ************************************
	initial begin
		logic [15:0] r, v, wm;
		logic [3:0] i;
		logic fits;
		target_e tg;
		repeat (8) @(posedge core_clk_i);
		@(negedge core_clk_i);
		arst_n_i <= 1'b1;
		ask(T_STD_LATCH, 1'b1, 4'd7, 16'h0001);
		ask(T_STD_LATCH, 1'b0, 4'd0, 16'h0000);
		$display("test power_on done");
		// Random events, one-bit read clears only that bit
		for (int n = 0; n < 12; n++) begin
			r = rnd();
			wm = (n % 3 == 1) ? 16'hffff : 16'h00ff;
			tg = (n % 3 == 0) ? T_STD_LATCH : (n % 3 == 1) ? T_INS_LATCH : T_MES_LATCH;
			v = r & wm & ((n % 3 == 0) ? 16'hfffd : 16'hffff);
			i = rnd() & wm[3:0] & ((n % 3 == 1) ? 4'hf : 4'h7);
			pulse((n % 3 == 0) ? {r[7:0], 24'h0} : (n % 3 == 1) ? {8'h00, r, 8'h00} : {24'h0, r[7:0]});
			ask(tg, 1'b1, i, {15'h0000, v[i]});
			ask(tg, 1'b0, 4'd0, v & ~(16'h0001 << i));
			ask(tg, 1'b0, 4'd0, 16'h0000);
		end
		$display("test latches done");
		// Whole and single-bit mask writes
		for (int n = 0; n < 8; n++) begin
			tg = (n % 4 == 0) ? T_STD_MASK : (n % 4 == 1) ? T_INS_MASK : (n % 4 == 2) ? T_MES_MASK : T_SRQ_MASK;
			wm = (n % 4 == 1) ? 16'hffff : 16'h00ff;
			r = rnd();
			i = rnd() & wm[3:0];
			put(tg, 1'b0, 4'd0, r);
			ask(tg, 1'b0, 4'd0, r & wm);
			// Bit writes above 7 on byte-wide masks are ignored, bit reads there give 0
			fits = (n % 4 == 1) || !i[3];
			put(tg, 1'b1, i, {15'h0000, ~r[i]});
			ask(tg, 1'b1, i, {15'h0000, fits & ~r[i]});
			ask(tg, 1'b0, 4'd0, (r & wm) ^ (fits ? (16'h0001 << i) : 16'h0000));
		end
		$display("test masks done");
		// Promotion into the status byte
		put(T_STD_MASK, 1'b0, 4'd0, 16'h0008);
		put(T_INS_MASK, 1'b0, 4'd0, 16'h1000);
		put(T_MES_MASK, 1'b0, 4'd0, 16'h0040);
		put(T_SRQ_MASK, 1'b0, 4'd0, 16'h0020);
		sb(8'h00);
		pulse({8'h08, 16'h0000, 8'h00});
		sb(8'h60);
		pulse({8'h00, 16'h1000, 8'h00});
		sb(8'h61);
		pulse({8'h00, 16'h0000, 8'h40});
		sb(8'h63);
		msg_avail_i <= 1'b1;
		rx_full_i <= 1'b1;
		sb(8'hf3);
		ask(T_STATUS_BYTE, 1'b0, 4'd0, 16'h00f3);
		ask(T_STATUS_BYTE, 1'b0, 4'd0, 16'h00f3);
		ask(T_MES_LATCH, 1'b0, 4'd0, 16'h0040);
		put(T_SRQ_MASK, 1'b0, 4'd0, 16'h0001);
		sb(8'hf1);
		ask(T_INS_LATCH, 1'b0, 4'd0, 16'h1000);
		sb(8'hb0);
		repeat (4) @(negedge core_clk_i);
		sb(8'hb0);
		$display("test status_byte done");
		// Clear status empties all latches and pulses abort
		pulse({8'h10, 16'h0001, 8'h01});
		clear_status_i <= 1'b1;
		@(negedge core_clk_i);
		clear_status_i <= 1'b0;
		check({15'h0000, abort_scan_o}, 16'h0001, "abort pulse");
		sb(8'h90);
		check({15'h0000, abort_scan_o}, 16'h0000, "abort end");
		ask(T_STD_LATCH, 1'b0, 4'd0, 16'h0000);
		ask(T_INS_LATCH, 1'b0, 4'd0, 16'h0000);
		ask(T_MES_LATCH, 1'b0, 4'd0, 16'h0000);
		// Sets aimed at a latch are refused
		put(T_STD_LATCH, 1'b0, 4'd0, 16'h00ff);
		ask(T_STD_LATCH, 1'b0, 4'd0, 16'h0000);
		// Event in the very cycle of a clearing read survives it
		fork
			ask(T_INS_LATCH, 1'b0, 4'd0, 16'h0000);
			pulse({8'h00, 16'h0008, 8'h00});
		join
		ask(T_INS_LATCH, 1'b0, 4'd0, 16'h0008);
		fork
			ask(T_MES_LATCH, 1'b0, 4'd0, 16'h0000);
			pulse({24'h000000, 8'h20});
		join
		ask(T_MES_LATCH, 1'b0, 4'd0, 16'h0020);
		$display("test clear done");
		// Timebase selection, all four combinations
		for (int k = 0; k < 4; k++) begin
			put(T_AUTO_TB, 1'b0, 4'd0, {15'h0000, k[1]});
			ext_ref_present_i <= k[0];
			@(negedge core_clk_i);
			v = k[0] ? (k[1] ? 16'h0001 : 16'h0002) : 16'h0000;
			check({14'h0000, timebase_state_o}, v, "timebase state");
			check({15'h0000, use_external_o}, {15'h0000, k[0] & k[1]}, "use external");
			ask(T_TIMEBASE, 1'b0, 4'd0, v);
			ask(T_AUTO_TB, 1'b0, 4'd0, {15'h0000, k[1]});
		end
		$display("test timebase done");
		// Second power-up mid-run: power-on bit again, standard mask cleared, automatic timebase
		@(negedge core_clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		arst_n_i <= 1'b1;
		ask(T_STD_LATCH, 1'b1, 4'd7, 16'h0001);
		ask(T_AUTO_TB, 1'b0, 4'd0, 16'h0001);
		ask(T_STD_MASK, 1'b0, 4'd0, 16'h0000);
		$display("test reset done");
		for (int w = 0; w < 10 && exp_q.size() > 0; w++)
			@(negedge core_clk_i);
		if (exp_q.size() > 0) begin
			failures++;
			$display("unexpected at %0t: replies missing", $time);
		end
		finish_test();
	end
endmodule // status_event_reporting_tb
